// [dv/ppx_page_expansion_bench.sv]
/*
 * Self-checking bench for the program page expansion block.
 * Assumes the stack model answers pops and pointer reads in the same cycle.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module ppx_page_expansion_bench;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [1:0]  paging_partition_strap_i, flash_alloc_strap_i;
	logic        flash_hide_control_i, port_k_emulation_enable_i, expanded_mode_i;
	logic        write_protect_i, ext_space_i, page_wr_i, call_req_i;
	logic        call_indirect_i, ret_req_i;
	logic [15:0] bus_addr_i, call_target_i, call_ret_addr_i, ind_target_i, stk_rdata_i;
	logic [5:0]  page_wdata_i, call_page_i, ind_page_i, page_index_register_o;
	logic [7:0]  gpio_out_i, gpio_oe_i, port_k_out_o, port_k_oe_o;
	logic        window_hit_o, window_internal_o, ecs_active_o, ind_rd_o;
	logic        stk_push_o, stk_pop_o, pc_load_o, queue_refill_o, irq_inhibit_o;
	logic [15:0] ind_ptr_o, stk_wdata_o, pc_value_o;
	int          errors = 0;
	int          total_checks = 0;

	ppx_page_expansion DUT (.clk_i, .rst_n_i, .paging_partition_strap_i,
		.flash_alloc_strap_i, .flash_hide_control_i, .port_k_emulation_enable_i,
		.expanded_mode_i, .write_protect_i, .bus_addr_i, .ext_space_i, .page_wr_i,
		.page_wdata_i, .call_req_i, .call_indirect_i, .call_page_i, .call_target_i,
		.call_ret_addr_i, .ind_page_i, .ind_target_i, .ret_req_i, .stk_rdata_i,
		.gpio_out_i, .gpio_oe_i, .page_index_register_o, .window_hit_o,
		.window_internal_o, .ecs_active_o, .ind_rd_o, .ind_ptr_o, .stk_push_o,
		.stk_wdata_o, .stk_pop_o, .pc_load_o, .pc_value_o, .queue_refill_o,
		.irq_inhibit_o, .port_k_out_o, .port_k_oe_o);

	ppx_stack_model stk (.clk_i, .rst_n_i, .stk_push_i(stk_push_o),
		.stk_wdata_i(stk_wdata_o), .stk_pop_i(stk_pop_o), .stk_rdata_o(stk_rdata_i),
		.ind_rd_i(ind_rd_o), .ind_ptr_i(ind_ptr_o), .ind_page_o(ind_page_i),
		.ind_target_o(ind_target_i));

	always #20 clk_i = ~clk_i;

	// ==========================================
	// helpers
	task cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task wr(input logic [5:0] p);
		page_wr_i = 1'b1;
		page_wdata_i = p;
		cyc(1);
		page_wr_i = 1'b0;
		cyc(1);
	endtask

	function automatic logic ecs_exp(input logic [1:0] a, r, input logic h, i);
		case (a)
			2'h0: return r < 2'h2;
			2'h1: return r != 2'h3;
			2'h2: return r == 2'h0 ? 1'b1 : r == 2'h1 ? h : r == 2'h2 ? !i : 1'b0;
			default: return r < 2'h2 ? h : r == 2'h2 ? !i : 1'b0;
		endcase
	endfunction

	task report_and_stop;
		$display("checks=%0d mismatches=%0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================
	// scenarios
	task t_reset_gpio;
		gpio_out_i = 8'hA5;
		gpio_oe_i = 8'h3C;
		cyc(1);
		`CHK(page_index_register_o, ppx_pkg::PAGE_RST)
		`CHK({port_k_out_o, port_k_oe_o}, 16'hA53C)
		port_k_emulation_enable_i = 1'b1;
		cyc(1);
		`CHK({port_k_out_o, port_k_oe_o}, 16'hA53C)
		$display("test reset_gpio done");
	endtask

	task t_write;
		wr(6'h15);
		`CHK(page_index_register_o, 6'h15)
		write_protect_i = 1'b1;
		wr(6'h2A);
		`CHK(page_index_register_o, 6'h15)
		write_protect_i = 1'b0;
		$display("test write done");
	endtask

	task t_partition;
		logic [5:0] lim [4];
		logic [5:0] pg [3];
		lim = '{6'h37, 6'h2F, 6'h1F, 6'h3F};
		for (int s = 0; s < 4; s++) begin
			paging_partition_strap_i = 2'(s);
			cyc(3);
			pg = '{6'h00, lim[s], lim[s] + 6'h01};
			for (int k = 0; k < 3; k++) begin
				wr(pg[k]);
				`CHK(window_internal_o, (s == 3) || (pg[k] > lim[s]))
			end
		end
		$display("test partition done");
	endtask

	task t_xaddr;
		logic [15:0] ad [7];
		logic [5:0]  e;
		ad = '{16'h3FFF, 16'h4000, 16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF};
		expanded_mode_i = 1'b1;
		wr(6'h2B);
		for (int k = 0; k < 7; k++) begin
			bus_addr_i = ad[k];
			cyc(1);
			e = ad[k][15:14] == 2'h2 ? 6'h2B : ad[k][15:14] == 2'h0 ? 6'h3D :
				ad[k][15:14] == 2'h1 ? 6'h3E : 6'h3F;
			`CHK(port_k_out_o[5:0], e)
			`CHK(window_hit_o, ad[k][15:14] == 2'h2)
			`CHK(port_k_oe_o, 8'hFF)
		end
		$display("test xaddr done");
	endtask

	task t_ecs;
		logic e;
		paging_partition_strap_i = 2'h2;
		for (int a = 0; a < 4; a++) begin
			flash_alloc_strap_i = 2'(a);
			cyc(3);
			for (int h = 0; h < 2; h++)
				for (int i = 0; i < 2; i++) begin
					wr(i ? 6'h20 : 6'h1F);
					for (int r = 0; r < 4; r++)
						for (int x = 0; x < 2; x++) begin
							flash_hide_control_i = 1'(h);
							ext_space_i = 1'(x);
							bus_addr_i = {2'(r), 14'h0100};
							cyc(1);
							e = ecs_exp(2'(a), 2'(r), 1'(h), 1'(i));
							`CHK(port_k_out_o[7], e)
							`CHK(port_k_out_o[6], !(e && x))
							`CHK(ecs_active_o, !e)
						end
				end
		end
		port_k_emulation_enable_i = 1'b0;
		cyc(1);
		`CHK(port_k_out_o, gpio_out_i)
		$display("test ecs done");
	endtask

	task do_call(input logic ind, input logic [15:0] tg, ra, et, input logic [5:0] np, old);
		call_indirect_i = ind;
		call_target_i = tg;
		call_ret_addr_i = ra;
		call_page_i = ind ? ~np : np;
		call_req_i = 1'b1;
		cyc(1);
		call_req_i = 1'b0;
		if (ind) begin
			`CHK({ind_rd_o, ind_ptr_o}, {1'b1, tg})
			cyc(1);
		end
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h10)
		page_wr_i = 1'b1;
		page_wdata_i = 6'h05;
		ret_req_i = 1'b1;
		cyc(1);
		page_wr_i = 1'b0;
		ret_req_i = 1'b0;
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h18)
		`CHK({stk_wdata_o, page_index_register_o}, {ra, np})
		cyc(1);
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h18)
		`CHK({stk_wdata_o, page_index_register_o}, {10'h000, old, np})
		cyc(1);
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h13)
		`CHK(pc_value_o, et)
		cyc(1);
		`CHK(irq_inhibit_o, 1'b0)
	endtask

	task do_ret(input logic [15:0] ra, input logic [5:0] old, cur);
		ret_req_i = 1'b1;
		cyc(1);
		ret_req_i = 1'b0;
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h14)
		cyc(1);
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h14)
		cyc(1);
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h12)
		`CHK({pc_value_o, page_index_register_o}, {ra, cur})
		cyc(1);
		`CHK({irq_inhibit_o, stk_push_o, stk_pop_o, pc_load_o, queue_refill_o}, 5'h11)
		`CHK(page_index_register_o, old)
		cyc(1);
		`CHK(irq_inhibit_o, 1'b0)
	endtask

	task t_call_ret;
		wr(6'h11);
		do_call(1'b0, 16'h9ABC, 16'h4567, 16'h9ABC, 6'h33, 6'h11);
		do_call(1'b1, 16'h0456, 16'hA0B2, 16'h1456, 6'h3C, 6'h33);
		do_ret(16'hA0B2, 6'h33, 6'h3C);
		do_ret(16'h4567, 6'h11, 6'h33);
		$display("test call_ret done");
	endtask

	// ==========================================
	// main sequence and watchdog
	initial begin
		{paging_partition_strap_i, flash_alloc_strap_i, flash_hide_control_i} = '0;
		{port_k_emulation_enable_i, expanded_mode_i, write_protect_i, ext_space_i} = '0;
		{page_wr_i, call_req_i, call_indirect_i, ret_req_i} = '0;
		{bus_addr_i, call_target_i, call_ret_addr_i, page_wdata_i, call_page_i} = '0;
		{gpio_out_i, gpio_oe_i} = '0;
		cyc(8);
		rst_n_i = 1'b1;
		cyc(2);
		t_reset_gpio();
		t_write();
		t_partition();
		t_xaddr();
		t_ecs();
		t_call_ret();
		report_and_stop();
	end

	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
endmodule

// [dv/ppx_stack_model.sv]
/*
 * Far-side model: stack memory and indirect operand memory.
 * Assumes push and pop pulses are taken on the rising clock edge.
 */
`timescale 1ns/10ps
module ppx_stack_model (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        stk_push_i,
	input  wire logic [15:0] stk_wdata_i,
	input  wire logic        stk_pop_i,
	output logic      [15:0] stk_rdata_o,
	input  wire logic        ind_rd_i,
	input  wire logic [15:0] ind_ptr_i,
	output logic      [5:0]  ind_page_o,
	output logic      [15:0] ind_target_o
);
	// ==========================================
	// stack storage
	logic [15:0] mem_r [8];
	logic [2:0]  sp_r;
	logic [15:0] junk_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sp_r   <= 3'h0;
			junk_r <= 16'h0000;
		end else begin
			junk_r <= ~junk_r;
			if (stk_push_i) begin
				mem_r[sp_r] <= stk_wdata_i;
				sp_r        <= sp_r + 3'h1;
			end else if (stk_pop_i) begin
				sp_r <= sp_r - 3'h1;
			end
		end
	end

	// ==========================================
	// read paths, toggling pattern when not read
	assign stk_rdata_o  = stk_pop_i ? mem_r[sp_r - 3'h1] : junk_r;
	assign ind_page_o   = ind_rd_i ? (ind_ptr_i[5:0] ^ 6'h2A) : junk_r[5:0];
	assign ind_target_o = ind_rd_i ? (ind_ptr_i + 16'h1000) : junk_r;
endmodule

// [rtl/ppx_page_expansion.sv]
/*
 * Program page expansion: page index register, paged call and return
 * sequencer, and extended address output on port K.
 * Assumes the core's stack and pointer memory answer in the same cycle,
 * and that bus address and control bits come from core-clock logic.
 */
//
// Summary of operation
// - six-bit page shows in window 8000-BFFF
// - two-bit strap splits page space on/off chip
// - low pages external, high pages internal
// - page register set by writes, call, return
// - top 16K block is never paged
// - call and return sequences block interrupts
// - call: swap page, push address, push page
// - new page immediate, or fetched when indirect
// - return: pull page, pull address, restore page
// - window access drives page on extended address
// - other regions drive fixed 3D, 3E, 3F
// - pins active only emulation and expanded mode
// - emulation select active low, flash-hide dependent
// - 0K: select low for window and top
// - 16K: select low only for top
// - 48K: window internal, mid when hide clear
// - 64K: lower blocks when hide clear
// - external select when emulation select inactive
// - plain write effective next cycle, direct call page a cycle later
// - emulation off: port K pins are GPIO
`timescale 1ns/10ps
module ppx_page_expansion #(
	parameter logic [5:0] PAGE_RESET = ppx_pkg::PAGE_RST
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [1:0]  paging_partition_strap_i,
	input  wire logic [1:0]  flash_alloc_strap_i,
	input  wire logic        flash_hide_control_i,
	input  wire logic        port_k_emulation_enable_i,
	input  wire logic        expanded_mode_i,
	input  wire logic        write_protect_i,
	input  wire logic [15:0] bus_addr_i,
	input  wire logic        ext_space_i,
	input  wire logic        page_wr_i,
	input  wire logic [5:0]  page_wdata_i,
	input  wire logic        call_req_i,
	input  wire logic        call_indirect_i,
	input  wire logic [5:0]  call_page_i,
	input  wire logic [15:0] call_target_i,
	input  wire logic [15:0] call_ret_addr_i,
	input  wire logic [5:0]  ind_page_i,
	input  wire logic [15:0] ind_target_i,
	input  wire logic        ret_req_i,
	input  wire logic [15:0] stk_rdata_i,
	input  wire logic [7:0]  gpio_out_i,
	input  wire logic [7:0]  gpio_oe_i,
	output logic      [5:0]  page_index_register_o,
	output logic             window_hit_o,
	output logic             window_internal_o,
	output logic             ecs_active_o,
	output logic             ind_rd_o,
	output logic      [15:0] ind_ptr_o,
	output logic             stk_push_o,
	output logic      [15:0] stk_wdata_o,
	output logic             stk_pop_o,
	output logic             pc_load_o,
	output logic      [15:0] pc_value_o,
	output logic             queue_refill_o,
	output logic             irq_inhibit_o,
	output logic      [7:0]  port_k_out_o,
	output logic      [7:0]  port_k_oe_o
);
	// ==========================================================
	// strap synchronisers
	logic [1:0] part_m_r;
	logic [1:0] part_r;
	logic [1:0] alloc_m_r;
	logic [1:0] alloc_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			part_m_r  <= ppx_pkg::PART_128K;
			part_r    <= ppx_pkg::PART_128K;
			alloc_m_r <= ppx_pkg::ALLOC_0K;
			alloc_r   <= ppx_pkg::ALLOC_0K;
		end else begin
			part_m_r  <= paging_partition_strap_i;
			part_r    <= part_m_r;
			alloc_m_r <= flash_alloc_strap_i;
			alloc_r   <= alloc_m_r;
		end
	end

	// ==========================================================
	// paged call / return sequencer
	ppx_pkg::ppx_seq_t state_r;
	ppx_pkg::ppx_seq_t state_nxt;
	logic [5:0]  page_r;
	logic [5:0]  temp_page_r;
	logic [5:0]  new_page_r;
	logic [15:0] target_r;
	logic [15:0] ret_addr_r;
	logic [15:0] wdata_r;
	logic [15:0] pc_r;
	logic        busy;

	assign busy = (state_r != ppx_pkg::SQ_IDLE);

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ppx_pkg::SQ_IDLE: begin
				if (call_req_i)
					state_nxt = call_indirect_i ? ppx_pkg::SQ_IND : ppx_pkg::SQ_CSWAP;
				else if (ret_req_i)
					state_nxt = ppx_pkg::SQ_RPULL_PG;
			end
			ppx_pkg::SQ_IND:      state_nxt = ppx_pkg::SQ_CSWAP;
			ppx_pkg::SQ_CSWAP:    state_nxt = ppx_pkg::SQ_CPUSH_RA;
			ppx_pkg::SQ_CPUSH_RA: state_nxt = ppx_pkg::SQ_CPUSH_PG;
			ppx_pkg::SQ_CPUSH_PG: state_nxt = ppx_pkg::SQ_CREFILL;
			ppx_pkg::SQ_RPULL_PG: state_nxt = ppx_pkg::SQ_RPULL_RA;
			ppx_pkg::SQ_RPULL_RA: state_nxt = ppx_pkg::SQ_RWRITE;
			ppx_pkg::SQ_RWRITE:   state_nxt = ppx_pkg::SQ_RREFILL;
			default:              state_nxt = ppx_pkg::SQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			state_r <= ppx_pkg::SQ_IDLE;
		else
			state_r <= state_nxt;
	end

	// call operands, captured on acceptance or indirect fetch
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			new_page_r <= ppx_pkg::PAGE_RST;
			target_r   <= '0;
			ret_addr_r <= '0;
		end else if (state_r == ppx_pkg::SQ_IDLE && call_req_i) begin
			new_page_r <= call_page_i;
			target_r   <= call_target_i;
			ret_addr_r <= call_ret_addr_i;
		end else if (state_r == ppx_pkg::SQ_IND) begin
			new_page_r <= ind_page_i;
			target_r   <= ind_target_i;
		end
	end

	// page index register; sequence owns it while busy
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			page_r      <= PAGE_RESET;
			temp_page_r <= ppx_pkg::PAGE_RST;
		end else if (state_r == ppx_pkg::SQ_CSWAP) begin
			temp_page_r <= page_r;
			page_r      <= new_page_r;
		end else if (state_r == ppx_pkg::SQ_RPULL_PG) begin
			temp_page_r <= stk_rdata_i[5:0];
		end else if (state_r == ppx_pkg::SQ_RWRITE) begin
			page_r <= temp_page_r;
		end else if (!busy && page_wr_i && !write_protect_i) begin
			page_r <= page_wdata_i;
		end
	end

	// stack write data and program counter value
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wdata_r <= '0;
			pc_r    <= '0;
		end else begin
			if (state_nxt == ppx_pkg::SQ_CPUSH_RA)
				wdata_r <= ret_addr_r;
			else if (state_nxt == ppx_pkg::SQ_CPUSH_PG)
				wdata_r <= {ppx_pkg::STK_PAD, temp_page_r};
			if (state_r == ppx_pkg::SQ_RPULL_RA)
				pc_r <= stk_rdata_i;
			else if (state_r == ppx_pkg::SQ_CPUSH_PG)
				pc_r <= target_r;
		end
	end

	assign ind_rd_o       = (state_r == ppx_pkg::SQ_IND);
	assign ind_ptr_o      = target_r;
	assign stk_push_o     = (state_r == ppx_pkg::SQ_CPUSH_RA) || (state_r == ppx_pkg::SQ_CPUSH_PG);
	assign stk_wdata_o    = wdata_r;
	assign stk_pop_o      = (state_r == ppx_pkg::SQ_RPULL_PG) || (state_r == ppx_pkg::SQ_RPULL_RA);
	assign pc_load_o      = (state_r == ppx_pkg::SQ_CREFILL) || (state_r == ppx_pkg::SQ_RWRITE);
	assign pc_value_o     = pc_r;
	assign queue_refill_o = (state_r == ppx_pkg::SQ_CREFILL) || (state_r == ppx_pkg::SQ_RREFILL);
	assign irq_inhibit_o  = busy;
	assign page_index_register_o = page_r;
	assign window_hit_o   = (bus_addr_i[15:14] == ppx_pkg::REG_WIN);

	// ==========================================================
	// port k decode
	ppx_xaddr_decode u_decode (
		.bus_addr_i                (bus_addr_i),
		.page_index_bits_i         (page_r),
		.partition_i               (part_r),
		.flash_alloc_i             (alloc_r),
		.flash_hide_control_i      (flash_hide_control_i),
		.port_k_emulation_enable_i (port_k_emulation_enable_i),
		.expanded_mode_i           (expanded_mode_i),
		.ext_space_i               (ext_space_i),
		.gpio_out_i                (gpio_out_i),
		.gpio_oe_i                 (gpio_oe_i),
		.port_k_out_o              (port_k_out_o),
		.port_k_oe_o               (port_k_oe_o),
		.win_internal_o            (window_internal_o),
		.ecs_active_o              (ecs_active_o)
	);

	// ==========================================================
	// checks
	logic emul;
	assign emul = port_k_emulation_enable_i & expanded_mode_i;

	a_call_sequence: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == ppx_pkg::SQ_IDLE && call_req_i && !call_indirect_i)
		|=> !stk_push_o ##1 (stk_push_o && stk_wdata_o == $past(call_ret_addr_i, 2))
		##1 stk_push_o ##1 (pc_load_o && queue_refill_o))
		else $error("paged call order wrong");
	a_call_page_swap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == ppx_pkg::SQ_CSWAP) |=> (page_r == $past(new_page_r)) ##1
		(stk_wdata_o[5:0] == $past(page_r, 2)))
		else $error("old page not pushed");
	a_ret_restore: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == ppx_pkg::SQ_RPULL_PG) |-> ##2 (pc_value_o == $past(stk_rdata_i, 1))
		##1 (page_r == $past(stk_rdata_i[5:0], 3)))
		else $error("paged return restore wrong");
	a_irq_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == ppx_pkg::SQ_IDLE && (call_req_i || ret_req_i))
		|=> irq_inhibit_o [*4])
		else $error("interrupt window inside sequence");
	a_write_timing: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!busy && page_wr_i && !write_protect_i) |=> (page_index_register_o == $past(page_wdata_i)))
		else $error("plain page write not effective next cycle");
	a_write_blocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(!busy && page_wr_i && write_protect_i && !call_req_i && !ret_req_i)
		|=> $stable(page_index_register_o))
		else $error("protected page write took effect");
	a_window_page: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && bus_addr_i[15:14] == ppx_pkg::REG_WIN) |-> (port_k_out_o[5:0] == page_r))
		else $error("window extended address not page");
	a_fixed_xaddr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && bus_addr_i[15:14] == ppx_pkg::REG_TOP) |-> (port_k_out_o[5:0] == 6'h3F
		&& !port_k_out_o[ppx_pkg::PK_ECS]))
		else $error("top block decode wrong");
	a_gpio_mode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!emul |-> (port_k_out_o == gpio_out_i && port_k_oe_o == gpio_oe_i))
		else $error("port k not gpio with emulation off");
	a_xcs_exclusive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && !port_k_out_o[ppx_pkg::PK_XCS]) |-> (port_k_out_o[ppx_pkg::PK_ECS]
		&& ext_space_i))
		else $error("both selects active");
	a_partition_class: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(part_r == ppx_pkg::PART_256K) |-> (window_internal_o == (page_r >= 6'h30)))
		else $error("partition class wrong");
	a_alloc16_ecs: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && alloc_r == ppx_pkg::ALLOC_16K) |->
		(port_k_out_o[ppx_pkg::PK_ECS] == (bus_addr_i[15:14] != ppx_pkg::REG_TOP)))
		else $error("16K select decode wrong");
	a_ind_fetch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == ppx_pkg::SQ_IDLE && call_req_i && call_indirect_i)
		|=> (ind_rd_o && ind_ptr_o == $past(call_target_i)) ##1 !ind_rd_o)
		else $error("indirect operand fetch wrong");
	a_ret_pulls: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(state_r == ppx_pkg::SQ_IDLE && ret_req_i && !call_req_i)
		|=> stk_pop_o ##1 stk_pop_o ##1 (pc_load_o && !stk_pop_o)
		##1 (queue_refill_o && !pc_load_o))
		else $error("paged return order wrong");
	a_page_held: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(busy && state_r != ppx_pkg::SQ_CSWAP && state_r != ppx_pkg::SQ_RWRITE)
		|=> $stable(page_index_register_o))
		else $error("page changed inside sequence");
	a_window_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		window_hit_o == (bus_addr_i >= 16'h8000 && bus_addr_i <= 16'hBFFF))
		else $error("window decode wrong");
	a_xaddr_lower: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && !bus_addr_i[15])
		|-> (port_k_out_o[5:0] == (bus_addr_i[14] ? 6'h3E : 6'h3D)))
		else $error("lower block extended address wrong");
	a_ecs_alloc0: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && alloc_r == ppx_pkg::ALLOC_0K)
		|-> (port_k_out_o[ppx_pkg::PK_ECS] == !bus_addr_i[15]))
		else $error("0K select decode wrong");
	a_ecs_alloc48: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && alloc_r == ppx_pkg::ALLOC_48K && !bus_addr_i[15])
		|-> (port_k_out_o[ppx_pkg::PK_ECS] == (bus_addr_i[14] ? flash_hide_control_i : 1'b1)))
		else $error("48K select decode wrong");
	a_ecs_alloc64: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(emul && alloc_r == ppx_pkg::ALLOC_64K && !bus_addr_i[15])
		|-> (port_k_out_o[ppx_pkg::PK_ECS] == flash_hide_control_i))
		else $error("64K select decode wrong");
	a_emul_drive: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		emul |-> (port_k_oe_o == 8'hFF))
		else $error("port k not driven in emulation");
	a_ecs_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		ecs_active_o == (emul && !port_k_out_o[ppx_pkg::PK_ECS]))
		else $error("select flag disagrees with pin");
	a_part_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(part_r == ppx_pkg::PART_128K) |-> (window_internal_o == (page_r >= 6'h38)))
		else $error("128K partition class wrong");
	a_part_full: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(part_r == ppx_pkg::PART_1M) |-> window_internal_o)
		else $error("full partition not internal");
endmodule

// [rtl/ppx_pkg.sv]
/*
 * Constants and types for the program page expansion block.
 * Assumes a 16-bit core address bus and a six-bit page index.
 */
package ppx_pkg;
	localparam int          PAGE_W       = 6;
	localparam int          ADDR_W       = 16;
	localparam logic [5:0]  PAGE_RST     = 6'h00;
	// top two address bits pick the 16K region
	localparam logic [1:0]  REG_LOW      = 2'h0;
	localparam logic [1:0]  REG_MID      = 2'h1;
	localparam logic [1:0]  REG_WIN      = 2'h2;
	localparam logic [1:0]  REG_TOP      = 2'h3;
	localparam logic [5:0]  XADDR_LOW    = 6'h3D;
	localparam logic [5:0]  XADDR_MID    = 6'h3E;
	localparam logic [5:0]  XADDR_TOP    = 6'h3F;
	// partition strap codes and last external page of each but 1M (all internal)
	localparam logic [1:0]  PART_128K    = 2'h0;
	localparam logic [1:0]  PART_256K    = 2'h1;
	localparam logic [1:0]  PART_512K    = 2'h2;
	localparam logic [1:0]  PART_1M      = 2'h3;
	localparam logic [5:0]  LAST_EXT_00  = 6'h37;
	localparam logic [5:0]  LAST_EXT_01  = 6'h2F;
	localparam logic [5:0]  LAST_EXT_10  = 6'h1F;
	// physical flash allocation codes
	localparam logic [1:0]  ALLOC_0K     = 2'h0;
	localparam logic [1:0]  ALLOC_16K    = 2'h1;
	localparam logic [1:0]  ALLOC_48K    = 2'h2;
	localparam logic [1:0]  ALLOC_64K    = 2'h3;
	// port k pin positions
	localparam int          PK_XCS       = 6;
	localparam int          PK_ECS       = 7;
	localparam logic [9:0]  STK_PAD      = 10'h000;

	typedef enum logic [3:0] {
		SQ_IDLE, SQ_IND, SQ_CSWAP, SQ_CPUSH_RA, SQ_CPUSH_PG, SQ_CREFILL,
		SQ_RPULL_PG, SQ_RPULL_RA, SQ_RWRITE, SQ_RREFILL
	} ppx_seq_t;

	// page window access is internal above the last external page
	function automatic logic ppx_is_internal(input logic [1:0] part, input logic [5:0] page);
		case (part)
			PART_128K: ppx_is_internal = (page > LAST_EXT_00);
			PART_256K: ppx_is_internal = (page > LAST_EXT_01);
			PART_512K: ppx_is_internal = (page > LAST_EXT_10);
			default:   ppx_is_internal = 1'b1;
		endcase
	endfunction
endpackage

// [rtl/ppx_xaddr_decode.sv]
/*
 * Extended address and chip select decode for port K.
 * Assumes all inputs are stable within one bus cycle; purely combinational.
 */
`timescale 1ns/10ps
module ppx_xaddr_decode (
	input  wire logic [15:0] bus_addr_i,
	input  wire logic [5:0]  page_index_bits_i,
	input  wire logic [1:0]  partition_i,
	input  wire logic [1:0]  flash_alloc_i,
	input  wire logic        flash_hide_control_i,
	input  wire logic        port_k_emulation_enable_i,
	input  wire logic        expanded_mode_i,
	input  wire logic        ext_space_i,
	input  wire logic [7:0]  gpio_out_i,
	input  wire logic [7:0]  gpio_oe_i,
	output logic      [7:0]  port_k_out_o,
	output logic      [7:0]  port_k_oe_o,
	output logic             win_internal_o,
	output logic             ecs_active_o
);
	// ==========================================================
	// region decode
	logic [1:0] region;
	logic       internal;
	logic       ecs_n;
	logic       xcs_n;
	logic [5:0] xaddr;
	logic       emul;
	logic [7:0] emul_pins;

	assign region   = bus_addr_i[15:14];
	assign internal = ppx_pkg::ppx_is_internal(partition_i, page_index_bits_i);
	assign win_internal_o = internal;
	assign emul     = port_k_emulation_enable_i & expanded_mode_i;

	always_comb begin
		case (region)
			ppx_pkg::REG_LOW: xaddr = ppx_pkg::XADDR_LOW;
			ppx_pkg::REG_MID: xaddr = ppx_pkg::XADDR_MID;
			ppx_pkg::REG_WIN: xaddr = page_index_bits_i;
			default:          xaddr = ppx_pkg::XADDR_TOP;
		endcase
	end

	// top block always selects, never paged
	always_comb begin
		ecs_n = 1'b1;
		case (flash_alloc_i)
			ppx_pkg::ALLOC_0K:
				ecs_n = (region == ppx_pkg::REG_LOW) || (region == ppx_pkg::REG_MID);
			ppx_pkg::ALLOC_16K:
				ecs_n = (region != ppx_pkg::REG_TOP);
			ppx_pkg::ALLOC_48K: begin
				case (region)
					ppx_pkg::REG_LOW: ecs_n = 1'b1;
					ppx_pkg::REG_MID: ecs_n = flash_hide_control_i;
					ppx_pkg::REG_WIN: ecs_n = ~internal;
					default:          ecs_n = 1'b0;
				endcase
			end
			default: begin
				case (region)
					ppx_pkg::REG_WIN: ecs_n = ~internal;
					ppx_pkg::REG_TOP: ecs_n = 1'b0;
					default:          ecs_n = flash_hide_control_i;
				endcase
			end
		endcase
	end

	assign ecs_active_o = emul & ~ecs_n;
	// external select only when emulation select idle
	assign xcs_n = ~(ecs_n & ext_space_i);
	assign emul_pins = {ecs_n, xcs_n, xaddr};

	// ==========================================================
	// port k pin sharing
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			assign port_k_out_o[gi] = emul ? emul_pins[gi] : gpio_out_i[gi];
			assign port_k_oe_o[gi]  = emul ? 1'b1 : gpio_oe_i[gi];
		end
	endgenerate
endmodule
